// ### core/tsw_pkg.sv
// constants for the transceiver status and wake-event block
// assumes a 250 MHz core clock and a digital clock period given below
package tsw_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 4;
	localparam int DIGITAL_CLOCK_PERIOD_NS      = 4;   // digital clock period
	localparam int DEB_COUNT_DCLK = 8195;
	localparam int DEB_CYC_DEF    = DEB_COUNT_DCLK * DIGITAL_CLOCK_PERIOD_NS
		/ CLK_PERIOD_NS;
	localparam int KEY_HOLD_NS    = 1000; // off-mode key low hold
	localparam int KEY_HOLD_CYC   = (KEY_HOLD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// serial command byte
	// ----------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam int CMD_MSB   = 7;
	localparam int CMD_LSB   = 5;
	localparam int ADR_MSB   = 4;
	localparam logic [2:0] CMD_RD_BUF = 3'h0;
	localparam logic [2:0] CMD_WR_BUF = 3'h1;
	localparam logic [2:0] CMD_RD_REG = 3'h2;
	localparam logic [2:0] CMD_WR_REG = 3'h3;
	localparam logic [2:0] CMD_OFF    = 3'h4;
	localparam logic [2:0] CMD_DEL    = 3'h5;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	// ----------------------------------------------------------------
	// status register
	// ----------------------------------------------------------------
	localparam logic [4:0] WAKE_EVENT_STATUS_ADR = 5'h08;
	localparam logic [7:0] BYTE_ZERO             = 8'h00;
	localparam int         KEYS                  = 5;

	typedef enum logic [1:0] {
		PH_CMD  = 2'b01,
		PH_DATA = 2'b10
	} tsw_phase_t;

endpackage

// ### core/tsw_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level; no bus coherence implied
`timescale 1ns/1ps
module tsw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] d_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d_async;
			sync_reg <= meta_reg;
		end
	end

	assign d_sync = sync_reg;

endmodule

// ### core/tsw_top.sv
// status, wake-event and serial register port of the transceiver
// assumes pins are asynchronous; active_mode, buffer_count and
// reg_rd_data come from logic on clk
//
// Summary of operation
// - interrupt on power-on, aux flag or key event
// - status read clears power, aux, interrupt; battery only if recovered
// - status register at address 8
// - key status bit is inverted key level
// - active mode key event restarts debounce
// - debounce end updates keys, interrupts, stops
// - same key again stops debounce silently
// - other key event restarts debounce from zero
// - debounce or power flag forces supply, clock
// - status read or clear command removes interrupt
// - off mode held key wakes, reset low
// - after settling, set key bit and interrupt
// - release reset on good supply and oscillator
// - wake rise sets power flag, irq on rise
// - battery flag clears on recovery plus read
// - off mode aux good sets flag, interrupts
// - active aux rise sets flag, irq on rise
// - byte framing, command then data, MSB first
// - buffer count shifted out during command byte
// - chip select low resets serial port
// - buffer write echoes command and data
// - register reads may run successively
// - command type bits 7..5, address 4..0
`timescale 1ns/1ps
module tsw_top
	import tsw_pkg::*;
#(
	parameter int DEB_CYCLES = DEB_CYC_DEF
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cs,
	input  wire logic       sck,
	input  wire logic       serial_data_in,
	input  wire logic [4:0] key_input,
	input  wire logic       wake_input_pin,
	input  wire logic       aux_operate,
	input  wire logic       aux_above_main,
	input  wire logic       external_supply_out_low,
	input  wire logic       external_supply_out_recovered,
	input  wire logic       dvcc_up,
	input  wire logic       osc_settled,
	input  wire logic       ext_supply_good,
	input  wire logic       active_mode,
	input  wire logic [7:0] buffer_count,
	input  wire logic [7:0] reg_rd_data,
	output logic            serial_data_out,
	output logic            serial_data_out_oe,
	output logic            irq,
	output logic            reset_out_b,
	output logic            supply_on,
	output logic            ext_supply_enable,
	output logic            clk_out_enable,
	output logic [4:0]      reg_addr,
	output logic            reg_wr,
	output logic            buf_wr,
	output logic [7:0]      wr_data,
	output logic            off_cmd
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic       cs_s, sck_s, sdi_s, wake_s, auxop_s, auxmn_s;
	logic       vlow_s, vrec_s, dvcc_s, osc_s, extg_s;
	logic [4:0] key_s, key_low_s;

	// keys synced inverted: cleared flops match released keys
	tsw_sync #(.W(16)) u_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.d_async ({cs, sck, serial_data_in, ~key_input, wake_input_pin,
			aux_operate, aux_above_main, external_supply_out_low, external_supply_out_recovered,
			dvcc_up, osc_settled, ext_supply_good}),
		.d_sync  ({cs_s, sck_s, sdi_s, key_low_s, wake_s, auxop_s, auxmn_s,
			vlow_s, vrec_s, dvcc_s, osc_s, extg_s})
	);

	assign key_s = ~key_low_s;

	// ----------------------------------------------------------------
	// serial port state
	// ----------------------------------------------------------------
	tsw_phase_t phase_reg, phase_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] rx_reg, rx_next, cmd_reg, cmd_next, last_reg, last_next;
	logic [7:0] tx_reg, tx_next, ld_byte, rxb, status_vec;
	logic [4:0] addr_reg, addr_next;
	logic       sck_prev_reg, cs_prev_reg, sdo_reg, sdo_next, oe_reg, oe_next;
	logic       ld_reg, ld_next, dbyte_reg, dbyte_next;
	logic       wr_reg, wr_next, bwr_reg, bwr_next, off_reg, off_next;
	logic       del_irq, stat_rd;
	logic [2:0] ctype;

	assign rxb   = {rx_reg[6:0], sdi_s};
	assign ctype = cmd_reg[CMD_MSB:CMD_LSB];

	// next byte to shift out: read data or echo
	always_comb begin
		if (ctype == CMD_RD_REG) begin
			ld_byte = (addr_reg == WAKE_EVENT_STATUS_ADR) ?
				status_vec : reg_rd_data;
		end else if (ctype == CMD_WR_BUF || ctype == CMD_WR_REG) begin
			ld_byte = last_reg;
		end else begin
			ld_byte = BYTE_ZERO;
		end
	end

	always_comb begin
		phase_next = phase_reg;
		bit_next   = bit_reg;
		rx_next    = rx_reg;
		cmd_next   = cmd_reg;
		last_next  = last_reg;
		tx_next    = tx_reg;
		addr_next  = addr_reg;
		sdo_next   = sdo_reg;
		oe_next    = 1'b1;
		ld_next    = 1'b0;
		dbyte_next = dbyte_reg;
		wr_next    = 1'b0;
		bwr_next   = 1'b0;
		off_next   = 1'b0;
		del_irq    = 1'b0;
		stat_rd    = 1'b0;
		if (!cs_s) begin
			phase_next = PH_CMD;
			bit_next   = '0;
			oe_next    = 1'b0;
			sdo_next   = 1'b0;
			dbyte_next = 1'b0;
			cmd_next   = BYTE_ZERO;
		end else if (!cs_prev_reg) begin
			sdo_next = buffer_count[7];
			tx_next  = {buffer_count[6:0], 1'b0};
		end else if (ld_reg) begin
			sdo_next = ld_byte[7];
			tx_next  = {ld_byte[6:0], 1'b0};
			if (ctype == CMD_RD_REG) begin
				addr_next = addr_reg + 5'h01;
				stat_rd = (addr_reg == WAKE_EVENT_STATUS_ADR);
			end else if (ctype == CMD_WR_REG && dbyte_reg) begin
				addr_next = addr_reg + 5'h01;
			end
		end else if (sck_s && !sck_prev_reg) begin
			rx_next  = rxb;
			bit_next = bit_reg + 3'h1;
			sdo_next = tx_reg[7];
			tx_next  = {tx_reg[6:0], 1'b0};
			if (bit_reg == BIT_LAST) begin
				last_next = rxb;
				ld_next   = 1'b1;
				if (phase_reg == PH_CMD) begin
					phase_next = PH_DATA;
					cmd_next   = rxb;
					addr_next  = rxb[ADR_MSB:0];
					dbyte_next = 1'b0;
					off_next   = (rxb[CMD_MSB:CMD_LSB] == CMD_OFF);
					del_irq    = (rxb[CMD_MSB:CMD_LSB] == CMD_DEL);
				end else begin
					dbyte_next = 1'b1;
					wr_next    = (ctype == CMD_WR_REG);
					bwr_next   = (ctype == CMD_WR_BUF);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_reg    <= PH_CMD;
			bit_reg      <= '0;
			rx_reg       <= BYTE_ZERO;
			cmd_reg      <= BYTE_ZERO;
			last_reg     <= BYTE_ZERO;
			tx_reg       <= BYTE_ZERO;
			addr_reg     <= '0;
			sdo_reg      <= 1'b0;
			oe_reg       <= 1'b0;
			ld_reg       <= 1'b0;
			dbyte_reg    <= 1'b0;
			wr_reg       <= 1'b0;
			bwr_reg      <= 1'b0;
			off_reg      <= 1'b0;
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b0;
		end else begin
			phase_reg    <= phase_next;
			bit_reg      <= bit_next;
			rx_reg       <= rx_next;
			cmd_reg      <= cmd_next;
			last_reg     <= last_next;
			tx_reg       <= tx_next;
			addr_reg     <= addr_next;
			sdo_reg      <= sdo_next;
			oe_reg       <= oe_next;
			ld_reg       <= ld_next;
			dbyte_reg    <= dbyte_next;
			wr_reg       <= wr_next;
			bwr_reg      <= bwr_next;
			off_reg      <= off_next;
			sck_prev_reg <= sck_s;
			cs_prev_reg  <= cs_s;
		end
	end

	// ----------------------------------------------------------------
	// status, debounce and wake state
	// ----------------------------------------------------------------
	logic [4:0]  key_st_reg, key_st_next, key_prev_reg, chg;
	logic [2:0]  deb_key_reg, deb_key_next, first;
	logic [13:0] deb_cnt_reg, deb_cnt_next;
	logic [7:0]  hold_reg, hold_next;
	logic        deb_run_reg, deb_run_next, pwr_reg, pwr_next;
	logic        lowb_reg, lowb_next, aux_reg, aux_next;
	logic        irq_reg, irq_next, set_irq, wake_prev_reg, auxm_prev_reg;
	logic        auxo_prev_reg, kpend_reg, kpend_next, ppend_reg, ppend_next;
	logic        rst_out_reg, rst_out_next, sup_reg, sup_next, wake;
	logic        force_reg, deb_end;

	assign status_vec = {key_st_reg, pwr_reg, lowb_reg, aux_reg};
	assign chg        = key_s ^ key_prev_reg;
	assign deb_end    = deb_run_reg
		&& deb_cnt_reg == 14'(DEB_CYCLES - 1);

	always_comb begin
		first = '0;
		for (int i = KEYS - 1; i >= 0; i--) begin
			if (chg[i]) begin
				first = 3'(i);
			end
		end
	end

	always_comb begin
		key_st_next  = key_st_reg;
		deb_key_next = deb_key_reg;
		deb_run_next = deb_run_reg;
		deb_cnt_next = deb_run_reg ? deb_cnt_reg + 14'h0001 : deb_cnt_reg;
		hold_next    = '0;
		pwr_next     = pwr_reg;
		lowb_next    = lowb_reg;
		aux_next     = aux_reg;
		kpend_next   = kpend_reg;
		ppend_next   = ppend_reg;
		sup_next     = sup_reg;
		rst_out_next = rst_out_reg;
		irq_next     = irq_reg;
		set_irq      = 1'b0;
		wake         = 1'b0;
		if (stat_rd) begin
			pwr_next = 1'b0;
			aux_next = 1'b0;
			irq_next = 1'b0;
			if (vrec_s) begin
				lowb_next = 1'b0;
			end
		end
		if (del_irq) begin
			irq_next = 1'b0;
		end
		if (off_reg) begin
			sup_next = 1'b0;
		end
		if (active_mode) begin
			if (chg != '0) begin
				if (deb_run_reg && chg[deb_key_reg]) begin
					deb_run_next = 1'b0;
				end else begin
					deb_run_next = 1'b1;
					deb_cnt_next = '0;
					deb_key_next = first;
				end
			end else if (deb_end) begin
				key_st_next  = ~key_s;
				set_irq      = 1'b1;
				deb_run_next = 1'b0;
			end
			if (wake_s && !wake_prev_reg) begin
				pwr_next = 1'b1;
				set_irq  = set_irq | !pwr_reg;
			end
			if (auxmn_s && !auxm_prev_reg) begin
				aux_next = 1'b1;
				set_irq  = set_irq | !aux_reg;
			end
		end else begin
			deb_run_next = 1'b0;
			if (key_s != '1) begin
				hold_next = (hold_reg == 8'(KEY_HOLD_CYC)) ?
					hold_reg : hold_reg + 8'h01;
			end
			if (hold_reg == 8'(KEY_HOLD_CYC - 1)) begin
				kpend_next = 1'b1;
				wake       = 1'b1;
			end
			if (wake_s && !wake_prev_reg) begin
				ppend_next = 1'b1;
				wake       = 1'b1;
			end
			if (auxop_s && !auxo_prev_reg) begin
				aux_next = 1'b1;
				set_irq  = 1'b1;
				wake     = 1'b1;
			end
		end
		if (dvcc_s && osc_s && (kpend_reg || ppend_reg)) begin
			kpend_next = 1'b0;
			ppend_next = 1'b0;
			set_irq    = 1'b1;
			if (kpend_reg) begin
				key_st_next = ~key_s;
			end
			if (ppend_reg) begin
				pwr_next = 1'b1;
			end
		end
		if (vlow_s) begin
			lowb_next = 1'b1;
		end
		if (set_irq) begin
			irq_next = 1'b1;
		end
		if (wake) begin
			sup_next     = 1'b1;
			rst_out_next = 1'b0;
		end else if (extg_s && osc_s) begin
			rst_out_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			key_st_reg    <= '0;
			key_prev_reg  <= '1;
			deb_key_reg   <= '0;
			deb_run_reg   <= 1'b0;
			deb_cnt_reg   <= '0;
			hold_reg      <= '0;
			pwr_reg       <= 1'b0;
			lowb_reg      <= 1'b0;
			aux_reg       <= 1'b0;
			kpend_reg     <= 1'b0;
			ppend_reg     <= 1'b0;
			sup_reg       <= 1'b0;
			rst_out_reg   <= 1'b0;
			irq_reg       <= 1'b0;
			force_reg     <= 1'b0;
			wake_prev_reg <= 1'b0;
			auxm_prev_reg <= 1'b0;
			auxo_prev_reg <= 1'b0;
		end else begin
			key_st_reg    <= key_st_next;
			key_prev_reg  <= key_s;
			deb_key_reg   <= deb_key_next;
			deb_run_reg   <= deb_run_next;
			deb_cnt_reg   <= deb_cnt_next;
			hold_reg      <= hold_next;
			pwr_reg       <= pwr_next;
			lowb_reg      <= lowb_next;
			aux_reg       <= aux_next;
			kpend_reg     <= kpend_next;
			ppend_reg     <= ppend_next;
			sup_reg       <= sup_next;
			rst_out_reg   <= rst_out_next;
			irq_reg       <= irq_next;
			force_reg     <= deb_run_reg | pwr_reg;
			wake_prev_reg <= wake_s;
			auxm_prev_reg <= auxmn_s;
			auxo_prev_reg <= auxop_s;
		end
	end

	assign serial_data_out    = sdo_reg;
	assign serial_data_out_oe = oe_reg;
	assign irq                = irq_reg;
	assign reset_out_b        = rst_out_reg;
	assign supply_on          = sup_reg;
	assign ext_supply_enable  = force_reg;
	assign clk_out_enable     = force_reg;
	assign reg_addr           = addr_reg;
	assign reg_wr             = wr_reg;
	assign buf_wr             = bwr_reg;
	assign wr_data            = last_reg;
	assign off_cmd            = off_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_DEB_IRQ: assert property (
		active_mode && chg == '0 && deb_end |=> irq_reg && !deb_run_reg)
		else $error("debounce end without interrupt");
	AST_KEY_INV: assert property (
		active_mode && chg == '0 && deb_end |=>
		key_st_reg == ~$past(key_s))
		else $error("key status not inverse of key level");
	AST_DEB_START: assert property (
		active_mode && chg != '0 && !deb_run_reg |=>
		deb_run_reg && deb_cnt_reg == '0 ##1 deb_cnt_reg == 14'h0001)
		else $error("debounce did not start from zero");
	AST_DEB_SAME: assert property (
		active_mode && deb_run_reg && chg[deb_key_reg] |=>
		!deb_run_reg && $stable(key_st_reg))
		else $error("same-key event did not stop debounce");
	AST_DEB_OTHER: assert property (
		active_mode && deb_run_reg && chg != '0 && !chg[deb_key_reg]
		|=> deb_run_reg && deb_cnt_reg == '0)
		else $error("other-key event did not restart debounce");
	AST_FORCE: assert property (
		(deb_run_reg || pwr_reg) |=> ext_supply_enable && clk_out_enable)
		else $error("supply and clock enables not forced");
	AST_STAT_CLR: assert property (
		stat_rd && !set_irq |=> !irq_reg && !aux_reg && !pwr_reg)
		else $error("status read did not clear flags");
	AST_DEL_IRQ: assert property (
		del_irq && !set_irq |=> !irq_reg)
		else $error("clear command left interrupt pending");
	AST_CS_RST: assert property (
		!cs_s |=> !serial_data_out_oe && bit_reg == '0)
		else $error("serial port active while deselected");
	AST_RST_REL: assert property (
		$rose(reset_out_b) |-> $past(extg_s && osc_s))
		else $error("reset released before supply good");

	COV_DEB: cover property (active_mode && chg == '0 && deb_end);
	COV_STAT: cover property (stat_rd ##1 !irq_reg);
	COV_DEL: cover property (del_irq);
	COV_WAKE: cover property (!active_mode && kpend_reg ##[1:50] irq_reg);

endmodule

// ### verification/tsw_host.sv
// host-side serial master model for the status block
// assumes clk at 250 MHz; sck period of 16 clk cycles (64 ns)
`timescale 1ns/1ps
module tsw_host (
	input  wire logic clk,
	input  wire logic serial_data_out,
	output logic      cs,
	output logic      sck,
	output logic      serial_data_in
);
	logic [7:0] tx [4];
	logic [7:0] rx [4];

	initial begin
		cs = 1'b0;
		sck = 1'b0;
		serial_data_in = 1'b0;
	end

	// ------------------------------------------------------------
	// one transfer of n whole bytes, msb first
	// ------------------------------------------------------------
	task automatic xfer(input int n);
		@(posedge clk);
		cs <= 1'b1;
		repeat (6) @(posedge clk);
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				serial_data_in <= tx[b][i];
				repeat (8) @(posedge clk);
				rx[b][i] = serial_data_out;
				sck <= 1'b1;
				repeat (8) @(posedge clk);
				sck <= 1'b0;
			end
		end
		// released data line shows no stale value
		serial_data_in <= ~serial_data_in;
		repeat (8) @(posedge clk);
		cs <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the status and wake-event block
// assumes tsw_host drives the serial pins; debounce shortened to 20
`timescale 1ns/1ps
module testbench
	import tsw_pkg::*;
;
	localparam int DEB = 20;
	logic        clk, rst_b, cs, sck, serial_data_in, serial_data_out;
	logic        serial_data_out_oe, irq, reset_out_b, supply_on;
	logic        ext_supply_enable, clk_out_enable, reg_wr, buf_wr;
	logic        off_cmd, wake_input_pin, aux_operate, aux_above_main;
	logic        external_supply_out_low, external_supply_out_recovered, dvcc_up, osc_settled;
	logic        ext_supply_good, active_mode;
	logic [4:0]  key_input, reg_addr;
	logic [7:0]  buffer_count, reg_rd_data, wr_data;
	logic [15:0] rs, r;
	int          n_errors, n_checks, n_buf, n_wr, n_off;
	logic        oe_seen;

	tsw_top #(.DEB_CYCLES(DEB)) i_tsw_top (
		.clk, .rst_b, .cs, .sck, .serial_data_in, .key_input,
		.wake_input_pin, .aux_operate, .aux_above_main, .external_supply_out_low,
		.external_supply_out_recovered, .dvcc_up, .osc_settled, .ext_supply_good,
		.active_mode, .buffer_count, .reg_rd_data, .serial_data_out,
		.serial_data_out_oe, .irq, .reset_out_b, .supply_on,
		.ext_supply_enable, .clk_out_enable, .reg_addr, .reg_wr,
		.buf_wr, .wr_data, .off_cmd
	);
	tsw_host i_tsw_host (
		.clk, .serial_data_out, .cs, .sck, .serial_data_in
	);

	assign reg_rd_data = {3'h5, reg_addr};
	always #2 clk = ~clk;
	always @(posedge clk) if (buf_wr === 1'b1) n_buf++;
	always @(posedge clk) if (reg_wr === 1'b1) n_wr++;
	always @(posedge clk) if (off_cmd === 1'b1) n_off++;
	always @(posedge clk) if (cs === 1'b1) oe_seen = serial_data_out_oe;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function logic [15:0] rnd();
		rs = rs ^ (rs << 7);
		rs = rs ^ (rs >> 9);
		rs = rs ^ (rs << 8);
		return rs;
	endfunction
	function logic [7:0] stat_exp(input logic [4:0] k,
		input logic [2:0] f);
		return {~k, f};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic rd_stat(input logic [7:0] exp);
		i_tsw_host.tx[0] = {CMD_RD_REG, WAKE_EVENT_STATUS_ADR};
		i_tsw_host.xfer(2);
		check(i_tsw_host.rx[0], buffer_count);
		check(i_tsw_host.rx[1], exp);
	endtask
	task automatic cmd(input logic [2:0] c);
		i_tsw_host.tx[0] = {c, 5'h00};
		i_tsw_host.xfer(1);
	endtask
	task report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		cyc(20000);
		n_errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		rs = 16'h640e;
		n_errors = 0;
		n_checks = 0;
		n_buf = 0;
		n_wr = 0;
		n_off = 0;
		oe_seen = 1'b0;
		key_input = 5'h1f;
		wake_input_pin = 1'b0;
		aux_operate = 1'b0;
		aux_above_main = 1'b0;
		external_supply_out_low = 1'b0;
		external_supply_out_recovered = 1'b1;
		dvcc_up = 1'b1;
		osc_settled = 1'b1;
		ext_supply_good = 1'b1;
		active_mode = 1'b1;
		buffer_count = 8'h00;
		cyc(4);
		rst_b <= 1'b1;
		cyc(10);
		check(reset_out_b, 1'b1);
		check(irq, 1'b0);
		for (int j = 0; j < 4; j++) begin
			r = rnd();
			buffer_count <= r[7:0];
			key_input <= key_input ^ (5'h01 << (r[10:8] % 3'h5));
			cyc(15);
			check(irq, 1'b0);
			cyc(20);
			check(irq, 1'b1);
			rd_stat(stat_exp(key_input, 3'h0));
			check(irq, 1'b0);
		end
		done("debounce");
		key_input <= key_input ^ 5'h04;
		cyc(8);
		check(ext_supply_enable, 1'b1);
		check(clk_out_enable, 1'b1);
		key_input <= key_input ^ 5'h04;
		cyc(40);
		check(irq, 1'b0);
		check(clk_out_enable, 1'b0);
		check(ext_supply_enable, 1'b0);
		key_input <= key_input ^ 5'h02;
		cyc(12);
		key_input <= key_input ^ 5'h08;
		cyc(18);
		check(irq, 1'b0);
		cyc(12);
		check(irq, 1'b1);
		rd_stat(stat_exp(key_input, 3'h0));
		done("restart");
		key_input <= key_input ^ 5'h10;
		cyc(35);
		check(irq, 1'b1);
		cmd(CMD_DEL);
		check(irq, 1'b0);
		rd_stat(stat_exp(key_input, 3'h0));
		wake_input_pin <= 1'b1;
		cyc(10);
		check(irq, 1'b1);
		check(ext_supply_enable, 1'b1);
		check(clk_out_enable, 1'b1);
		wake_input_pin <= 1'b0;
		cmd(CMD_DEL);
		check(clk_out_enable, 1'b1);
		wake_input_pin <= 1'b1;
		cyc(10);
		check(irq, 1'b0);
		wake_input_pin <= 1'b0;
		rd_stat(stat_exp(key_input, 3'h4));
		cyc(4);
		check(ext_supply_enable, 1'b0);
		check(irq, 1'b0);
		aux_above_main <= 1'b1;
		cyc(10);
		check(irq, 1'b1);
		aux_above_main <= 1'b0;
		cmd(CMD_DEL);
		aux_above_main <= 1'b1;
		cyc(10);
		check(irq, 1'b0);
		aux_above_main <= 1'b0;
		rd_stat(stat_exp(key_input, 3'h1));
		done("flags");
		external_supply_out_recovered <= 1'b0;
		external_supply_out_low <= 1'b1;
		cyc(8);
		external_supply_out_low <= 1'b0;
		rd_stat(stat_exp(key_input, 3'h2));
		rd_stat(stat_exp(key_input, 3'h2));
		external_supply_out_recovered <= 1'b1;
		rd_stat(stat_exp(key_input, 3'h2));
		rd_stat(stat_exp(key_input, 3'h0));
		done("battery");
		r = rnd();
		i_tsw_host.tx[0] = {CMD_WR_BUF, 5'h00};
		i_tsw_host.tx[1] = r[7:0];
		i_tsw_host.tx[2] = ~r[7:0];
		n_buf = 0;
		i_tsw_host.xfer(3);
		check(i_tsw_host.rx[1], i_tsw_host.tx[0]);
		check(i_tsw_host.rx[2], r[7:0]);
		check(wr_data, ~r[7:0]);
		check(n_buf[7:0], 8'h02);
		check(oe_seen, 1'b1);
		check(serial_data_out_oe, 1'b0);
		i_tsw_host.tx[0] = {CMD_WR_REG, 5'h03};
		i_tsw_host.xfer(2);
		check({3'h0, reg_addr}, 8'h04);
		check(n_wr[7:0], 8'h01);
		check(wr_data, r[7:0]);
		i_tsw_host.tx[0] = {CMD_RD_REG, 5'h09};
		i_tsw_host.xfer(3);
		check(i_tsw_host.rx[1], 8'ha9);
		check(i_tsw_host.rx[2], 8'haa);
		done("serial");
		key_input <= 5'h1f;
		cyc(40);
		rd_stat(stat_exp(5'h1f, 3'h0));
		cmd(CMD_OFF);
		check(supply_on, 1'b0);
		check(n_off[7:0], 8'h01);
		active_mode <= 1'b0;
		dvcc_up <= 1'b0;
		osc_settled <= 1'b0;
		ext_supply_good <= 1'b0;
		cyc(4);
		key_input <= 5'h1e;
		cyc(KEY_HOLD_CYC + 20);
		check(reset_out_b, 1'b0);
		check(supply_on, 1'b1);
		check(irq, 1'b0);
		dvcc_up <= 1'b1;
		osc_settled <= 1'b1;
		cyc(10);
		check(irq, 1'b1);
		check(reset_out_b, 1'b0);
		ext_supply_good <= 1'b1;
		cyc(10);
		check(reset_out_b, 1'b1);
		active_mode <= 1'b1;
		rd_stat(stat_exp(5'h1e, 3'h0));
		cmd(CMD_OFF);
		check(supply_on, 1'b0);
		check(n_off[7:0], 8'h02);
		active_mode <= 1'b0;
		aux_operate <= 1'b1;
		cyc(10);
		check(irq, 1'b1);
		check(supply_on, 1'b1);
		active_mode <= 1'b1;
		rd_stat(stat_exp(5'h1e, 3'h1));
		done("wake");
		report_and_stop();
	end
endmodule
